// >>> hw/plcpd_consts.vh
// constants for the second analog loop control and power-down register bank
// assumes word-indexed registers on a 32-bit bus, byte address is four times the index
//
// Contract
// - 3-bit pump current code, default 100
// - 2-bit series resistor code, default 01
// - 2-bit parallel capacitor code, default 01
// - one-bit second pole select, default 1
// - one-bit lock count select, default 1
// - one-bit lock override, default automatic (0)
// - manual oscillator select, default first oscillator
// - 5-bit first oscillator lock value, default 01011
// - 5-bit second oscillator lock value, default 00000
// - synthesizer mode flag, default 0
// - reserved bits written zero, read undefined
// - crystal doubler bypass bit, default 0
// - two input reference disable bits, default 0
// - second analog loop disable bit, default 0
// - eight output pair disable bits, default 0
// - two digital loop disable bits, default 0
// - two calibration hold bits, default 0
`ifndef PLCPD_CONSTS_VH
`define PLCPD_CONSTS_VH

// register indices, byte address is index times four
`define PLCPD_IDX_LOOP_FILTER 10'h0b0
`define PLCPD_IDX_LOCK_MODE 10'h0b1
`define PLCPD_IDX_VCO1_MANUAL 10'h0b2
`define PLCPD_IDX_VCO2_MANUAL 10'h0b3
`define PLCPD_IDX_PD_RESERVED 10'h0b4
`define PLCPD_IDX_INPUT_REF 10'h0b5
`define PLCPD_IDX_ANALOG_PLL 10'h0b6
`define PLCPD_IDX_OUTPUT 10'h0b7
`define PLCPD_IDX_DIGITAL_CAL 10'h0b8
`define PLCPD_IDX_DOUBLER 10'h0f0

// field positions (lsb)
`define PLCPD_PUMP_LSB 5
`define PLCPD_RES_LSB 3
`define PLCPD_CAP_LSB 1
`define PLCPD_POLE_LSB 0
`define PLCPD_SYN_LSB 3
`define PLCPD_LCNT_LSB 1
`define PLCPD_OVR_LSB 0
`define PLCPD_VSEL_LSB 5
`define PLCPD_LOCKV_LSB 0
`define PLCPD_DBL_LSB 0
`define PLCPD_REF_LSB 0
`define PLCPD_APLL_LSB 4
`define PLCPD_OUT_LSB 0
`define PLCPD_DPLL_LSB 2
`define PLCPD_CAL_LSB 0

// reset values
`define PLCPD_PUMP_RST 3'h4
`define PLCPD_RES_RST 2'h1
`define PLCPD_CAP_RST 2'h1
`define PLCPD_POLE_RST 1'h1
`define PLCPD_LCNT_RST 1'h1
`define PLCPD_OVR_RST 1'h0
`define PLCPD_SYN_RST 1'h0
`define PLCPD_VSEL_RST 1'h1
`define PLCPD_LOCKV1_RST 5'h0b
`define PLCPD_LOCKV2_RST 5'h00
`define PLCPD_DBL_RST 1'h0
`define PLCPD_REF_RST 2'h0
`define PLCPD_APLL_RST 1'h0
`define PLCPD_OUT_RST 8'h00
`define PLCPD_DPLL_RST 2'h0
`define PLCPD_CAL_RST 2'h0

// bus answers
`define PLCPD_RDATA_RST 32'h0000_0000
`define PLCPD_WAIT_RST 1'h1
`define PLCPD_BUS_RST 1'h0
`define PLCPD_TAKE_IDX_RST 10'h000
`define PLCPD_TAKE_BIT_RST 1'h0
`define PLCPD_TAKE_DATA_RST 8'h00

`endif

// >>> hw/plcpd_field.v
// one software-writable control field held in flip-flops
// assumes a synchronous active-low reset and a one-cycle write strobe
`timescale 1ns/10ps
module plcpd_field #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_write_en,
    input wire [W-1:0] i_data,
    output wire [W-1:0] o_value
);
    reg [W-1:0] value_r;

    // load default at reset, new value on strobe
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            value_r <= RST;
        end else if (i_write_en) begin
            value_r <= i_data;
        end
    end

    assign o_value = value_r;
endmodule // plcpd_field

// >>> hw/plcpd_regs.v
// control and power-down register bank for the second analog loop
// assumes an avalon-mm master with byte addresses and one outstanding request
`timescale 1ns/10ps
`include "plcpd_consts.vh"
module plcpd_regs #(
    parameter AW = 12
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire [AW-1:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [3:0] i_byteenable,
    output wire [31:0] o_readdata,
    output wire o_waitrequest,
    output wire [2:0] o_pump_current_code_b,
    output wire [1:0] o_series_resistor_code_b,
    output wire [1:0] o_parallel_capacitor_code_b,
    output wire o_second_pole_select_b,
    output wire o_lock_count_select_b,
    output wire o_lock_override_b,
    output wire o_synthesizer_mode_b,
    output wire o_manual_oscillator_select_b,
    output wire [4:0] o_first_oscillator_lock_value_b,
    output wire [4:0] o_second_oscillator_lock_value_b,
    output wire o_crystal_doubler_bypass,
    output wire [1:0] o_input_reference_off,
    output wire o_analog_loop_b_off,
    output wire [7:0] o_output_pair_off,
    output wire [1:0] o_digital_loop_off,
    output wire [1:0] o_calibration_hold
);
    // bus sequencer states
    localparam [0:0] BUS_IDLE = 1'b0;
    localparam [0:0] BUS_ANSWER = 1'b1;

    // bus handshake state
    reg bus_state_r;
    reg bus_state_nxt;
    reg wait_r;
    reg wait_nxt;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    reg [7:0] rd_byte;

    // request as taken at the edge that starts the transfer
    reg [9:0] take_idx_r;
    reg [9:0] take_idx_nxt;
    reg take_wr_r;
    reg take_wr_nxt;
    reg take_lane_r;
    reg take_lane_nxt;
    reg [7:0] take_data_r;
    reg [7:0] take_data_nxt;

    // decode helpers
    wire [9:0] idx;
    wire req;
    wire wr_commit;
    wire [7:0] wd;

    // per-register write strobes
    wire we_loop;
    wire we_lock;
    wire we_vco1;
    wire we_vco2;
    wire we_ref;
    wire we_apll;
    wire we_out;
    wire we_dcal;
    wire we_dbl;

    // word index from byte address, low lane only
    assign idx = i_address[AW-1:2];
    assign req = i_read | i_write;
    assign wd = take_data_r; // low lane as taken with the request

    // write lands only at the edge that ends the wait, from the request as taken
    assign wr_commit = (bus_state_r == BUS_ANSWER) & take_wr_r & take_lane_r;

    // loop control strobes, index latched so a late address change cannot steer a write
    assign we_loop = wr_commit & (take_idx_r == `PLCPD_IDX_LOOP_FILTER);
    assign we_lock = wr_commit & (take_idx_r == `PLCPD_IDX_LOCK_MODE);
    assign we_vco1 = wr_commit & (take_idx_r == `PLCPD_IDX_VCO1_MANUAL);
    assign we_vco2 = wr_commit & (take_idx_r == `PLCPD_IDX_VCO2_MANUAL);
    // power-down strobes, unmapped and reserved indices write nothing
    assign we_ref = wr_commit & (take_idx_r == `PLCPD_IDX_INPUT_REF);
    assign we_apll = wr_commit & (take_idx_r == `PLCPD_IDX_ANALOG_PLL);
    assign we_out = wr_commit & (take_idx_r == `PLCPD_IDX_OUTPUT);
    assign we_dcal = wr_commit & (take_idx_r == `PLCPD_IDX_DIGITAL_CAL);
    assign we_dbl = wr_commit & (take_idx_r == `PLCPD_IDX_DOUBLER);

    // loop filter register fields
    // pump current, eight equal steps up from code 0
    plcpd_field #(.W(3), .RST(`PLCPD_PUMP_RST)) u_pump (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_loop),
        .i_data(wd[`PLCPD_PUMP_LSB +: 3]),
        .o_value(o_pump_current_code_b)
    );

    // series resistor, larger codes give more resistance
    plcpd_field #(.W(2), .RST(`PLCPD_RES_RST)) u_res (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_loop),
        .i_data(wd[`PLCPD_RES_LSB +: 2]),
        .o_value(o_series_resistor_code_b)
    );

    // parallel capacitor, larger codes give more capacitance
    plcpd_field #(.W(2), .RST(`PLCPD_CAP_RST)) u_cap (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_loop),
        .i_data(wd[`PLCPD_CAP_LSB +: 2]),
        .o_value(o_parallel_capacitor_code_b)
    );

    // second pole network choice
    plcpd_field #(.W(1), .RST(`PLCPD_POLE_RST)) u_pole (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_loop),
        .i_data(wd[`PLCPD_POLE_LSB +: 1]),
        .o_value(o_second_pole_select_b)
    );

    // lock mode register fields, value chosen by software per capacitor
    // lock accuracy, 1 picks the coarse count
    plcpd_field #(.W(1), .RST(`PLCPD_LCNT_RST)) u_lcnt (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_lock),
        .i_data(wd[`PLCPD_LCNT_LSB +: 1]),
        .o_value(o_lock_count_select_b)
    );

    // 1 hands lock control to the manual values
    plcpd_field #(.W(1), .RST(`PLCPD_OVR_RST)) u_ovr (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_lock),
        .i_data(wd[`PLCPD_OVR_LSB +: 1]),
        .o_value(o_lock_override_b)
    );

    // free-run forcing lives in another bank, not checked here
    // 1 runs the loop from the crystal alone
    plcpd_field #(.W(1), .RST(`PLCPD_SYN_RST)) u_syn (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_lock),
        .i_data(wd[`PLCPD_SYN_LSB +: 1]),
        .o_value(o_synthesizer_mode_b)
    );

    // manual lock fields
    // oscillator used while the lock is manual, 1 is the first
    plcpd_field #(.W(1), .RST(`PLCPD_VSEL_RST)) u_vsel (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_vco1),
        .i_data(wd[`PLCPD_VSEL_LSB +: 1]),
        .o_value(o_manual_oscillator_select_b)
    );

    // manual lock value for the first oscillator
    plcpd_field #(.W(5), .RST(`PLCPD_LOCKV1_RST)) u_lockv1 (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_vco1),
        .i_data(wd[`PLCPD_LOCKV_LSB +: 5]),
        .o_value(o_first_oscillator_lock_value_b)
    );

    // manual lock value for the second oscillator
    plcpd_field #(.W(5), .RST(`PLCPD_LOCKV2_RST)) u_lockv2 (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_vco2),
        .i_data(wd[`PLCPD_LOCKV_LSB +: 5]),
        .o_value(o_second_oscillator_lock_value_b)
    );

    // power-down fields
    // 1 feeds the plain crystal frequency, no doubling
    plcpd_field #(.W(1), .RST(`PLCPD_DBL_RST)) u_dbl (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_dbl),
        .i_data(wd[`PLCPD_DBL_LSB +: 1]),
        .o_value(o_crystal_doubler_bypass)
    );

    // one off bit per input reference
    plcpd_field #(.W(2), .RST(`PLCPD_REF_RST)) u_ref (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_ref),
        .i_data(wd[`PLCPD_REF_LSB +: 2]),
        .o_value(o_input_reference_off)
    );

    // 1 stops the second analog loop
    plcpd_field #(.W(1), .RST(`PLCPD_APLL_RST)) u_apll (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_apll),
        .i_data(wd[`PLCPD_APLL_LSB +: 1]),
        .o_value(o_analog_loop_b_off)
    );

    // one off bit per output pair, its driver floats when set
    plcpd_field #(.W(8), .RST(`PLCPD_OUT_RST)) u_out (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_out),
        .i_data(wd[`PLCPD_OUT_LSB +: 8]),
        .o_value(o_output_pair_off)
    );

    // one off bit per digital loop
    plcpd_field #(.W(2), .RST(`PLCPD_DPLL_RST)) u_dpll (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_dcal),
        .i_data(wd[`PLCPD_DPLL_LSB +: 2]),
        .o_value(o_digital_loop_off)
    );

    // 1 holds that analog loop's calibration logic
    plcpd_field #(.W(2), .RST(`PLCPD_CAL_RST)) u_cal (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_write_en(we_dcal),
        .i_data(wd[`PLCPD_CAL_LSB +: 2]),
        .o_value(o_calibration_hold)
    );

    // read mux, reserved positions read as zero
    always @* begin
        rd_byte = 8'h00;
        case (idx)
            `PLCPD_IDX_LOOP_FILTER: begin
                rd_byte[`PLCPD_PUMP_LSB +: 3] = o_pump_current_code_b;
                rd_byte[`PLCPD_RES_LSB +: 2] = o_series_resistor_code_b;
                rd_byte[`PLCPD_CAP_LSB +: 2] = o_parallel_capacitor_code_b;
                rd_byte[`PLCPD_POLE_LSB] = o_second_pole_select_b;
            end
            `PLCPD_IDX_LOCK_MODE: begin
                rd_byte[`PLCPD_SYN_LSB] = o_synthesizer_mode_b;
                rd_byte[`PLCPD_LCNT_LSB] = o_lock_count_select_b;
                rd_byte[`PLCPD_OVR_LSB] = o_lock_override_b;
            end
            `PLCPD_IDX_VCO1_MANUAL: begin
                rd_byte[`PLCPD_VSEL_LSB] = o_manual_oscillator_select_b;
                rd_byte[`PLCPD_LOCKV_LSB +: 5] = o_first_oscillator_lock_value_b;
            end
            `PLCPD_IDX_VCO2_MANUAL: begin
                rd_byte[`PLCPD_LOCKV_LSB +: 5] = o_second_oscillator_lock_value_b;
            end
            `PLCPD_IDX_INPUT_REF: begin
                rd_byte[`PLCPD_REF_LSB +: 2] = o_input_reference_off;
            end
            `PLCPD_IDX_ANALOG_PLL: begin
                rd_byte[`PLCPD_APLL_LSB] = o_analog_loop_b_off;
            end
            `PLCPD_IDX_OUTPUT: begin
                rd_byte[`PLCPD_OUT_LSB +: 8] = o_output_pair_off;
            end
            `PLCPD_IDX_DIGITAL_CAL: begin
                rd_byte[`PLCPD_DPLL_LSB +: 2] = o_digital_loop_off;
                rd_byte[`PLCPD_CAL_LSB +: 2] = o_calibration_hold;
            end
            `PLCPD_IDX_DOUBLER: begin
                rd_byte[`PLCPD_DBL_LSB] = o_crystal_doubler_bypass;
            end
            default: begin
                rd_byte = 8'h00; // reserved index and unmapped space
            end
        endcase
    end

    // take the request in idle, answer for one cycle, then go back to idle
    always @* begin
        bus_state_nxt = bus_state_r;
        wait_nxt = wait_r;
        rdata_nxt = rdata_r;
        take_idx_nxt = take_idx_r;
        take_wr_nxt = take_wr_r;
        take_lane_nxt = take_lane_r;
        take_data_nxt = take_data_r;
        case (bus_state_r)
            BUS_IDLE: begin
                wait_nxt = 1'b1;
                if (req) begin
                    bus_state_nxt = BUS_ANSWER;
                    wait_nxt = 1'b0; // answer in the next cycle
                    take_idx_nxt = idx;
                    take_wr_nxt = i_write;
                    take_lane_nxt = i_byteenable[0];
                    take_data_nxt = i_writedata[7:0];
                    if (i_read) begin
                        rdata_nxt = {24'h00_0000, rd_byte}; // upper lanes read zero
                    end
                end
            end
            BUS_ANSWER: begin
                bus_state_nxt = BUS_IDLE; // returns even if the master let go early
                wait_nxt = 1'b1;
                take_wr_nxt = 1'b0;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
                wait_nxt = 1'b1;
                take_wr_nxt = 1'b0;
            end
        endcase
    end

    // handshake and request flip-flops
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            bus_state_r <= `PLCPD_BUS_RST;
            wait_r <= `PLCPD_WAIT_RST;
            rdata_r <= `PLCPD_RDATA_RST;
            take_idx_r <= `PLCPD_TAKE_IDX_RST;
            take_wr_r <= `PLCPD_TAKE_BIT_RST;
            take_lane_r <= `PLCPD_TAKE_BIT_RST;
            take_data_r <= `PLCPD_TAKE_DATA_RST;
        end else begin
            bus_state_r <= bus_state_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            take_idx_r <= take_idx_nxt;
            take_wr_r <= take_wr_nxt;
            take_lane_r <= take_lane_nxt;
            take_data_r <= take_data_nxt;
        end
    end

    assign o_waitrequest = wait_r;
    assign o_readdata = rdata_r;
endmodule // plcpd_regs

// >>> sim/plcpd_regs_asserts.sv
// port assertions for the loop control and power-down register bank
// assumes one clock and a synchronous active-low reset; bound after the module
`timescale 1ns/10ps
module plcpd_regs_asserts #(
    parameter AW = 12
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire [AW-1:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [3:0] i_byteenable,
    input wire [31:0] o_readdata,
    input wire o_waitrequest,
    input wire [2:0] o_pump_current_code_b,
    input wire [1:0] o_series_resistor_code_b,
    input wire [1:0] o_parallel_capacitor_code_b,
    input wire o_second_pole_select_b,
    input wire [4:0] o_first_oscillator_lock_value_b,
    input wire [7:0] o_output_pair_off
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // request taken, then one low cycle of waitrequest
    sequence s_taken;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_answer;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    sequence s_rd_filter;
        i_read && o_waitrequest && i_address[AW-1:2] == 10'h0b0;
    endsequence
    sequence s_rd_reserved;
        i_read && o_waitrequest && i_address[AW-1:2] == 10'h0b4;
    endsequence
    sequence s_wr_output;
        i_write && !o_waitrequest && i_byteenable[0] && i_address[AW-1:2] == 10'h0b7;
    endsequence
    a_wait_one_cycle: assert property (s_taken |=> s_answer)
        else $error("waitrequest not low for exactly one cycle");
    a_wait_idle_high: assert property (!(i_read || i_write) |=> o_waitrequest)
        else $error("waitrequest low without request");
    a_reset_defaults: assert property (disable iff (1'b0) !i_reset_n |=>
        o_pump_current_code_b == 3'h4 && o_series_resistor_code_b == 2'h1 &&
        o_parallel_capacitor_code_b == 2'h1 && o_second_pole_select_b &&
        o_first_oscillator_lock_value_b == 5'h0b && o_output_pair_off == 8'h00)
        else $error("field not at default after reset");
    a_upper_zero: assert property (o_readdata[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    a_read_filter: assert property (s_rd_filter |=>
        o_readdata[7:0] == $past({o_pump_current_code_b, o_series_resistor_code_b,
        o_parallel_capacitor_code_b, o_second_pole_select_b}))
        else $error("loop filter read mismatch");
    a_reserved_read: assert property (s_rd_reserved |=> o_readdata == 32'h0)
        else $error("reserved register read not zero");
    a_output_write: assert property (s_wr_output |=>
        o_output_pair_off == $past(i_writedata[7:0])) else $error("output disable not written");
    a_fields_hold: assert property (!(i_write && !o_waitrequest) |=>
        $stable({o_pump_current_code_b, o_first_oscillator_lock_value_b, o_output_pair_off}))
        else $error("field changed without write");
endmodule // plcpd_regs_asserts

bind plcpd_regs plcpd_regs_asserts #(.AW(AW)) plcpd_regs_asserts_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_pump_current_code_b(o_pump_current_code_b),
    .o_series_resistor_code_b(o_series_resistor_code_b),
    .o_parallel_capacitor_code_b(o_parallel_capacitor_code_b),
    .o_second_pole_select_b(o_second_pole_select_b),
    .o_first_oscillator_lock_value_b(o_first_oscillator_lock_value_b),
    .o_output_pair_off(o_output_pair_off)
);

// >>> sim/plcpd_regs_bench.sv
// self-checking bench for the loop control and power-down register bank
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/10ps
module plcpd_regs_bench;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic [11:0] i_address = 12'h000;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'h0;
    wire [31:0] o_readdata;
    wire o_waitrequest;
    wire [37:0] fld;
    logic [9:0] idx_t [10] = '{10'h0b0, 10'h0b1, 10'h0b2, 10'h0b3, 10'h0b4,
        10'h0b5, 10'h0b6, 10'h0b7, 10'h0b8, 10'h0f0};
    logic [7:0] msk_t [10] = '{8'hff, 8'h0b, 8'h3f, 8'h1f, 8'h00, 8'h03, 8'h10, 8'hff, 8'h0f, 8'h01};
    logic [7:0] dfl_t [10] = '{8'h8b, 8'h02, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] sh [10];
    logic [31:0] exp_q [$];
    int miscompares = 0;
    int total_checks = 0;

    plcpd_regs plcpd_regs_inst (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_pump_current_code_b(fld[37:35]), .o_series_resistor_code_b(fld[34:33]),
        .o_parallel_capacitor_code_b(fld[32:31]), .o_second_pole_select_b(fld[30]),
        .o_synthesizer_mode_b(fld[29]), .o_lock_count_select_b(fld[28]),
        .o_lock_override_b(fld[27]), .o_manual_oscillator_select_b(fld[26]),
        .o_first_oscillator_lock_value_b(fld[25:21]),
        .o_second_oscillator_lock_value_b(fld[20:16]), .o_crystal_doubler_bypass(fld[15]),
        .o_input_reference_off(fld[14:13]), .o_analog_loop_b_off(fld[12]),
        .o_output_pair_off(fld[11:4]), .o_digital_loop_off(fld[3:2]),
        .o_calibration_hold(fld[1:0])
    );

    // 40 MHz clock
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end

    // field outputs expected from the shadow copy
    function automatic logic [37:0] fld_exp();
        return {sh[0], sh[1][3], sh[1][1:0], sh[2][5:0], sh[3][4:0], sh[9][0], sh[5][1:0],
            sh[6][4], sh[7], sh[8][3:0]};
    endfunction

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] ix, input logic [31:0] d,
            input logic [3:0] be);
        int n;
        n = 0;
        i_address <= {ix, 2'b00};
        i_writedata <= d;
        i_byteenable <= be;
        i_read <= !wr;
        i_write <= wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            test_done();
        end
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic do_reset(input int cyc);
        i_reset_n <= 1'b0;
        repeat (cyc) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        foreach (sh[k]) sh[k] = dfl_t[k];
    endtask

    // field check, then read back every register and one unmapped index
    task automatic sweep();
        check("fields", {26'h0, fld}, {26'h0, fld_exp()});
        for (int k = 0; k < 10; k++) begin
            exp_q.push_back({24'h0, sh[k] & msk_t[k]});
            bus(1'b0, idx_t[k], 32'h0, 4'hf);
        end
        exp_q.push_back(32'h0);
        bus(1'b0, 10'h0c0, 32'h0, 4'hf);
    endtask

    // compares each read answer with the oldest noted expectation
    always @(posedge i_clock) begin
        if (i_read && o_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) check("stray read", 64'h1, 64'h0);
            else check("readdata", {32'h0, o_readdata}, {32'h0, exp_q.pop_front()});
        end
    end

    initial begin
        logic [7:0] d;
        void'($urandom(61));
        do_reset(16);
        sweep();
        for (int r = 0; r < 5; r++) begin
            for (int k = 0; k < 10; k++) begin
                d = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($urandom);
                sh[k] = d & msk_t[k];
                bus(1'b1, idx_t[k], ($urandom & 32'hffffff00) | {24'h0, sh[k]}, 4'h1);
            end
            bus(1'b1, 10'h0c0, $urandom, 4'h1);
            sweep();
        end
        bus(1'b1, 10'h0b7, 32'h0000_00a5, 4'h0);
        bus(1'b1, 10'h0b1, 32'h0000_0000, 4'h1); // count 0 for a large capacitor
        bus(1'b1, 10'h0b1, 32'h0000_0008, 4'h1); // synthesizer mode bit set in the lock mode register
        sh[1] = 8'h08;
        sweep();
        do_reset(2);
        sweep();
        test_done();
    end
endmodule // plcpd_regs_bench
